// *** rtl/uart_pin_ctrl_pkg.sv ***
package uart_pin_ctrl_pkg;

  // Bus style strap values
  localparam logic BUS_STYLE_STROBE_PAIR = 1'b1;
  localparam logic BUS_STYLE_RW_SELECT   = 1'b0;

  // Idle line levels
  localparam logic LINE_IDLE_NORMAL   = 1'b1;
  localparam logic LINE_IDLE_INFRARED = 1'b0;

  // Modem control field positions (user side control word)
  localparam int MCTL_DTR_BIT    = 0;
  localparam int MCTL_RTS_BIT    = 1;
  localparam int MCTL_INT_OE_BIT = 3;
  localparam int MCTL_IR_BIT     = 6;
  localparam int MCTL_WIDTH      = 8;

  // Modem status field positions (active-high view of the inputs)
  localparam int MSTS_CTS_BIT = 0;
  localparam int MSTS_DSR_BIT = 1;
  localparam int MSTS_RI_BIT  = 2;
  localparam int MSTS_CD_BIT  = 3;
  localparam int MSTS_WIDTH   = 4;

  // Reset pulse timing
  localparam int RESET_MIN_NS    = 40;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int RESET_MIN_CYC   = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CNT_WIDTH = 4;

  // Reset values
  localparam logic [MCTL_WIDTH-1:0] MCTL_RESET = 8'h00;
  localparam logic [MSTS_WIDTH-1:0] MSTS_RESET = 4'h0;

endpackage

// *** rtl/uart_pin_mode_reset_control.sv ***
`timescale 1ns/10ps

// Notes on behaviour
// - Strap high selects strobe-pair bus style; strap low selects read/write-select style.
// - Reset pin is active high for strobe-pair style, active low otherwise.
// - During reset transmit line is high, receive input ignored, outputs other than bus style (which follows the strap) at reset values.
// - Receive idles high normally, low in infrared; activity judged against that idle.
// - Clear-to-send readable as general input and gates transmit under auto flow control.
// - Data-terminal-ready output, active low, drivable as a plain general output.
// - Data-set-ready, carrier-detect, ring inputs are active low and readable.
// - Power-save high isolates the host data bus from internal logic.
// - Interrupt: active high, enabled by output-enable bit, in strobe-pair style; else active-low open drain.
// - Transmit idles high normally and low in infrared mode.
module uart_pin_mode_reset_control
  import uart_pin_ctrl_pkg::*;
#(
  parameter int SYNC_STAGES = 3
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_bus_style_strap,
  input  wire logic                  i_reset_pin,
  input  wire logic                  i_power_save_input,
  input  wire logic                  i_rx_pin,
  input  wire logic                  i_cts_n,
  input  wire logic                  i_dsr_n,
  input  wire logic                  i_cd_n,
  input  wire logic                  i_ri_n,
  input  wire logic [7:0]            i_host_wdata,
  input  wire logic                  i_host_wr,
  input  wire logic [MCTL_WIDTH-1:0] i_modem_ctrl,
  input  wire logic                  i_auto_cts_en,
  input  wire logic                  i_tx_data,
  input  wire logic                  i_tx_active,
  input  wire logic                  i_irq_event,
  output logic                       o_bus_strobe_pair,
  output logic                       o_device_reset,
  output logic                       o_tx_pin,
  output logic                       o_rts_n,
  output logic                       o_dtr_n,
  output logic                       o_int_out,
  output logic                       o_int_oe,
  output logic                       o_rx_activity,
  output logic                       o_rx_data,
  output logic [MSTS_WIDTH-1:0]      o_modem_status,
  output logic                       o_tx_allowed,
  output logic [7:0]                 o_host_wdata,
  output logic                       o_host_wr
);

  if (SYNC_STAGES != 3) begin : g_bad_stages
    $error("SYNC_STAGES must be 3");
  end

  // Three-stage synchronisers; a change counts when stages 2 and 3 agree
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1, s2, s3, clean;
  logic [NPIN-1:0] next_s1, next_s2, next_s3, next_clean;
  assign pin_raw = {i_bus_style_strap, i_reset_pin, i_power_save_input, i_rx_pin,
                    i_cts_n, i_dsr_n, i_cd_n, i_ri_n};

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_comb begin
        next_s1[g]    = pin_raw[g];
        next_s2[g]    = s1[g];
        next_s3[g]    = s2[g];
        next_clean[g] = (s2[g] == s3[g]) ? s3[g] : clean[g];
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // Idle pattern: strap high, reset pin inactive, power save off, rx and modem inputs high
      s1    <= 8'h9f;
      s2    <= 8'h9f;
      s3    <= 8'h9f;
      clean <= 8'h9f;
    end else begin
      s1    <= next_s1;
      s2    <= next_s2;
      s3    <= next_s3;
      clean <= next_clean;
    end
  end

  logic strap_q, reset_pin_q, psave_q, rx_q, cts_q, dsr_q, cd_q, ri_q;
  assign {strap_q, reset_pin_q, psave_q, rx_q, cts_q, dsr_q, cd_q, ri_q} = clean;

  // Reset decode and minimum width qualification
  logic                       reset_level;
  logic [RESET_CNT_WIDTH-1:0] rst_cnt, next_rst_cnt;
  logic                       dev_rst, next_dev_rst;
  assign reset_level = (strap_q == BUS_STYLE_STROBE_PAIR) ? reset_pin_q : ~reset_pin_q;

  always_comb begin
    next_rst_cnt = rst_cnt;
    next_dev_rst = dev_rst;
    if (!reset_level) begin
      next_rst_cnt = '0;
      next_dev_rst = 1'b0;
    end else if (rst_cnt < RESET_CNT_WIDTH'(RESET_MIN_CYC)) begin
      next_rst_cnt = rst_cnt + 1'b1;
    end else begin
      next_dev_rst = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rst_cnt <= '0;
      dev_rst <= 1'b0;
    end else begin
      rst_cnt <= next_rst_cnt;
      dev_rst <= next_dev_rst;
    end
  end

  logic any_rst;
  assign any_rst = i_rst | dev_rst;

  // Output registers
  logic                  ir_mode;
  logic                  next_bus, next_tx, next_rts, next_dtr, next_int, next_int_oe;
  logic                  next_act, next_rxd, next_allow, next_hwr;
  logic [MSTS_WIDTH-1:0] next_msts;
  logic [7:0]            next_hwd;
  logic                  rx_idle;
  assign ir_mode = i_modem_ctrl[MCTL_IR_BIT];
  assign rx_idle = ir_mode ? LINE_IDLE_INFRARED : LINE_IDLE_NORMAL;

  always_comb begin
    next_bus    = strap_q;
    next_allow  = ~i_auto_cts_en | ~cts_q;
    next_tx     = rx_idle;
    if (i_tx_active && next_allow) begin
      next_tx = i_tx_data;
    end else begin
      next_tx = ir_mode ? LINE_IDLE_INFRARED : LINE_IDLE_NORMAL;
    end
    next_rts    = ~i_modem_ctrl[MCTL_RTS_BIT];
    next_dtr    = ~i_modem_ctrl[MCTL_DTR_BIT];
    next_act    = (rx_q != rx_idle);
    next_rxd    = ir_mode ? ~rx_q : rx_q;
    next_msts   = '0;
    next_msts[MSTS_CTS_BIT] = ~cts_q;
    next_msts[MSTS_DSR_BIT] = ~dsr_q;
    next_msts[MSTS_RI_BIT]  = ~ri_q;
    next_msts[MSTS_CD_BIT]  = ~cd_q;
    if (strap_q == BUS_STYLE_STROBE_PAIR) begin
      next_int    = i_irq_event;
      next_int_oe = i_modem_ctrl[MCTL_INT_OE_BIT];
    end else begin
      next_int    = 1'b0;
      next_int_oe = i_irq_event;
    end
    next_hwd = psave_q ? 8'h00 : i_host_wdata;
    next_hwr = psave_q ? 1'b0 : i_host_wr;
  end

  always_ff @(posedge i_core_clk) begin
    if (any_rst) begin
      o_bus_strobe_pair <= next_bus;
      o_device_reset    <= 1'b1;
      o_tx_pin          <= 1'b1;
      o_rts_n           <= 1'b1;
      o_dtr_n           <= 1'b1;
      o_int_out         <= 1'b0;
      o_int_oe          <= 1'b0;
      o_rx_activity     <= 1'b0;
      o_rx_data         <= 1'b1;
      o_modem_status    <= MSTS_RESET;
      o_tx_allowed      <= 1'b0;
      o_host_wdata      <= 8'h00;
      o_host_wr         <= 1'b0;
    end else begin
      o_bus_strobe_pair <= next_bus;
      o_device_reset    <= 1'b0;
      o_tx_pin          <= next_tx;
      o_rts_n           <= next_rts;
      o_dtr_n           <= next_dtr;
      o_int_out         <= next_int;
      o_int_oe          <= next_int_oe;
      o_rx_activity     <= next_act;
      o_rx_data         <= next_rxd;
      o_modem_status    <= next_msts;
      o_tx_allowed      <= next_allow;
      o_host_wdata      <= next_hwd;
      o_host_wr         <= next_hwr;
    end
  end

  property p_tx_high_in_reset;
    @(posedge i_core_clk) disable iff (i_rst) dev_rst |=> o_tx_pin && !o_rx_activity;
  endproperty
  a_tx_high_in_reset: assert property (p_tx_high_in_reset) else $error("tx not high in reset");

  property p_psave_blocks_wr;
    @(posedge i_core_clk) disable iff (any_rst) psave_q |=> !o_host_wr && o_host_wdata == 8'h00;
  endproperty
  a_psave_blocks_wr: assert property (p_psave_blocks_wr) else $error("write passed in power save");

  property p_cts_gates_tx;
    @(posedge i_core_clk) disable iff (any_rst) (i_auto_cts_en && cts_q) |=> !o_tx_allowed;
  endproperty
  a_cts_gates_tx: assert property (p_cts_gates_tx) else $error("tx allowed with cts off");

  property p_tx_idle_level;
    @(posedge i_core_clk) disable iff (any_rst) !i_tx_active |=> o_tx_pin == !$past(ir_mode);
  endproperty
  a_tx_idle_level: assert property (p_tx_idle_level) else $error("tx idle level wrong");

  property p_rx_activity;
    @(posedge i_core_clk) disable iff (any_rst) (rx_q == rx_idle) |=> !o_rx_activity;
  endproperty
  a_rx_activity: assert property (p_rx_activity) else $error("activity flagged at idle");

  property p_dtr_follows;
    @(posedge i_core_clk) disable iff (any_rst) 1'b1 |=> o_dtr_n == !$past(i_modem_ctrl[MCTL_DTR_BIT]);
  endproperty
  a_dtr_follows: assert property (p_dtr_follows) else $error("dtr mismatch");

  property p_msts_inputs;
    @(posedge i_core_clk) disable iff (any_rst)
      1'b1 |=> o_modem_status[MSTS_DSR_BIT] == !$past(dsr_q) && o_modem_status[MSTS_RI_BIT] == !$past(ri_q);
  endproperty
  a_msts_inputs: assert property (p_msts_inputs) else $error("modem status mismatch");

  property p_int_style;
    @(posedge i_core_clk) disable iff (any_rst) (strap_q == BUS_STYLE_RW_SELECT) |=> !o_int_out;
  endproperty
  a_int_style: assert property (p_int_style) else $error("open drain drives high");

  property p_reset_polarity;
    @(posedge i_core_clk) disable iff (i_rst) !reset_level |=> !dev_rst;
  endproperty
  a_reset_polarity: assert property (p_reset_polarity) else $error("reset polarity wrong");

  property p_bus_style;
    @(posedge i_core_clk) disable iff (i_rst) 1'b1 |=> o_bus_strobe_pair == $past(strap_q);
  endproperty
  a_bus_style: assert property (p_bus_style) else $error("bus style mismatch");

endmodule

// *** tb/uart_host_model.sv ***
`timescale 1ns/10ps

module uart_host_model (
  input  wire logic       i_core_clk,
  output logic            o_reset_pin,
  output logic [7:0]      o_wdata,
  output logic            o_wr
);
  initial begin
    o_reset_pin = 1'b0;
    o_wdata     = 8'hff;
    o_wr        = 1'b0;
  end

  task automatic set_reset(input logic v);
    @(posedge i_core_clk);
    o_reset_pin <= v;
  endtask

  task automatic write(input logic [7:0] d);
    @(posedge i_core_clk);
    o_wdata <= d;
    o_wr    <= 1'b1;
  endtask

  // A released bus must not keep showing the last byte
  task automatic release_bus();
    @(posedge i_core_clk);
    o_wdata <= ~o_wdata;
    o_wr    <= 1'b0;
  endtask
endmodule

// *** tb/tb_uart_pin_mode_reset_control.sv ***
`timescale 1ns/10ps

module tb_uart_pin_mode_reset_control
  import uart_pin_ctrl_pkg::*;
;
  logic       clk, rst, strap, psave, rx, cts_n, dsr_n, cd_n, ri_n, auto, txd, txa, irq;
  logic       rpin, wr, owr, sp, drst, txp, rts_n, dtr_n, io, ioe, act, rxd, tx_ok;
  logic [7:0] ctrl, wd, owd;
  logic [3:0] sts;
  int         num_errors, samples_checked;

  uart_pin_mode_reset_control i_dut (
    .i_core_clk(clk), .i_rst(rst), .i_bus_style_strap(strap), .i_reset_pin(rpin),
    .i_power_save_input(psave), .i_rx_pin(rx), .i_cts_n(cts_n), .i_dsr_n(dsr_n),
    .i_cd_n(cd_n), .i_ri_n(ri_n), .i_host_wdata(wd), .i_host_wr(wr), .i_modem_ctrl(ctrl),
    .i_auto_cts_en(auto), .i_tx_data(txd), .i_tx_active(txa), .i_irq_event(irq),
    .o_bus_strobe_pair(sp), .o_device_reset(drst), .o_tx_pin(txp), .o_rts_n(rts_n),
    .o_dtr_n(dtr_n), .o_int_out(io), .o_int_oe(ioe), .o_rx_activity(act), .o_rx_data(rxd),
    .o_modem_status(sts), .o_tx_allowed(tx_ok), .o_host_wdata(owd), .o_host_wr(owr)
  );

  uart_host_model i_host (.i_core_clk(clk), .o_reset_pin(rpin), .o_wdata(wd), .o_wr(wr));

  always #4 clk = ~clk;

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic t_reset_pin();
    @(posedge clk);
    txa <= 1'b1;
    txd <= 1'b0;
    rx <= 1'b0;
    ctrl <= 8'h03;
    // An 8 ns pulse is too short to reset
    i_host.set_reset(1'b1);
    i_host.set_reset(1'b0);
    for (int i = 0; i < 10; i++) begin
      w(1);
      check(drst, 1'b0);
    end
    i_host.set_reset(1'b1);
    w(12);
    check(drst, 1'b1);
    check(txp, 1'b1);
    check({rts_n, dtr_n}, 2'h3);
    check(act, 1'b0);
    check(rxd, 1'b1);
    i_host.set_reset(1'b0);
    w(8);
    check(drst, 1'b0);
    check(txp, 1'b0);
    check({rts_n, dtr_n}, 2'h0);
    check(act, 1'b1);
    check(rxd, 1'b0);
  endtask

  task automatic t_style();
    @(posedge clk);
    strap <= BUS_STYLE_RW_SELECT;
    ctrl <= 8'h08;
    i_host.set_reset(1'b1);
    w(8);
    check(sp, 1'b0);
    check(drst, 1'b0);
    @(posedge clk);
    irq <= 1'b1;
    w(2);
    check({io, ioe}, 2'h1);
    @(posedge clk);
    irq <= 1'b0;
    w(2);
    check(ioe, 1'b0);
    i_host.set_reset(1'b0);
    w(12);
    check(drst, 1'b1);
    @(posedge clk);
    strap <= BUS_STYLE_STROBE_PAIR;
    i_host.set_reset(1'b0);
    w(10);
    check(sp, 1'b1);
    check(drst, 1'b0);
    @(posedge clk);
    irq <= 1'b1;
    w(2);
    check({io, ioe}, 2'h3);
    @(posedge clk);
    ctrl <= 8'h00;
    w(2);
    check(ioe, 1'b0);
    @(posedge clk);
    irq <= 1'b0;
  endtask

  task automatic t_line();
    logic idle;
    @(posedge clk);
    txa <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int r = 0; r < 2; r++) begin
        idle = m[0] ? LINE_IDLE_INFRARED : LINE_IDLE_NORMAL;
        @(posedge clk);
        ctrl <= m[0] ? 8'h40 : 8'h00;
        rx <= r[0];
        w(8);
        check(act, r[0] ^ idle);
        check(rxd, r[0] ^ m[0]);
        check(txp, idle);
      end
    end
  endtask

  task automatic t_modem();
    @(posedge clk);
    ctrl <= 8'h01;
    w(2);
    check({rts_n, dtr_n}, 2'h2);
    @(posedge clk);
    ctrl <= 8'h02;
    w(2);
    check({rts_n, dtr_n}, 2'h1);
    @(posedge clk);
    auto <= 1'b1;
    txa <= 1'b1;
    w(8);
    check(tx_ok, 1'b0);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cts_n <= (k != 0);
      dsr_n <= (k != 1);
      ri_n  <= (k != 2);
      cd_n  <= (k != 3);
      txd   <= k[1];
      w(8);
      check(sts, 4'h1 << k);
      check(tx_ok, k == 0);
      check(txp, k != 0);
    end
    @(posedge clk);
    cts_n <= 1'b1;
    dsr_n <= 1'b1;
    ri_n  <= 1'b1;
    cd_n  <= 1'b1;
    txa   <= 1'b0;
  endtask

  task automatic t_psave();
    i_host.write(8'ha5);
    w(2);
    check(owr, 1'b1);
    check(owd, 8'ha5);
    @(posedge clk);
    psave <= 1'b1;
    w(8);
    check(owr, 1'b0);
    check(owd, 8'h00);
    @(posedge clk);
    psave <= 1'b0;
    w(8);
    check(owr, 1'b1);
    check(owd, 8'ha5);
    i_host.release_bus();
    w(2);
    check(owr, 1'b0);
    check(owd, 8'h5a);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    clk = 1'b0;
    psave = 1'b0;
    auto = 1'b0;
    txa = 1'b0;
    irq = 1'b0;
    ctrl = 8'h00;
    rst = 1'b1;
    strap = 1'b1;
    rx = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    cd_n = 1'b1;
    ri_n = 1'b1;
    txd = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    w(8);
    t_reset_pin();
    $display("reset pin test done");
    t_style();
    $display("bus style test done");
    t_line();
    $display("line idle test done");
    t_modem();
    $display("modem test done");
    t_psave();
    $display("power save test done");
    report_and_stop();
  end
endmodule
